/* shared/tfpa_map.vh */
// tfpa_map.vh: register offsets, field positions and reset values of the timer block
// assumes an 8-bit register port with a 5-bit byte address
`ifndef TFPA_MAP_VH
`define TFPA_MAP_VH

`define TFPA_OFS_SELECT 5'h00
`define TFPA_OFS_SYSCTL 5'h01
`define TFPA_OFS_ACT_HI 5'h02
`define TFPA_OFS_ACT_LO 5'h03
`define TFPA_OFS_EDGE_HI 5'h04
`define TFPA_OFS_EDGE_LO 5'h05
`define TFPA_OFS_CMASK 5'h06
`define TFPA_OFS_OVFCTL 5'h07
`define TFPA_OFS_CFLAG 5'h08
`define TFPA_OFS_OFLAG 5'h09
`define TFPA_OFS_CNT_H 5'h0A
`define TFPA_OFS_CNT_L 5'h0B
`define TFPA_OFS_ACCUMULATOR_CONTROL 5'h0C
`define TFPA_OFS_PAFLAG 5'h0D
`define TFPA_OFS_PACNT_H 5'h0E
`define TFPA_OFS_PACNT_L 5'h0F

// system control bits
`define TFPA_B_TIMER_ON 7
`define TFPA_B_FFCA 4
// overflow and prescale control bits
`define TFPA_B_OVF_IE 7
`define TFPA_B_COMPARE7_COUNTER_RESET_ENABLE 3
`define TFPA_B_PRESCALE 0
// overflow flag register
`define TFPA_B_TOF 7
// accumulator control bits
`define TFPA_B_PA_EN 6
`define TFPA_B_PA_MODE 5
`define TFPA_B_PA_POL 4
`define TFPA_B_CLK_SEL 2
`define TFPA_B_PA_OVF_IE 1
`define TFPA_B_PA_IN_IE 0
// accumulator flag register
`define TFPA_B_PA_OVF 1
`define TFPA_B_PA_IN 0

`define TFPA_RST_BYTE 8'h00
`define TFPA_RST_WORD 16'h0000
`define TFPA_MAX_WORD 16'hFFFF
`define TFPA_DIV64_LAST 6'h3F

`endif

/* logic/tfpa_timer.v */
// tfpa_timer.v: eight-channel 16-bit timer with flags, compare/capture and pulse accumulator
// assumes one 100 MHz clock, a byte-wide register port on it, and timer pins from outside
`timescale 1ns/1ps
`default_nettype none
`include "tfpa_map.vh"

module tfpa_timer (
  input wire clk, // 100 MHz system clock
  input wire nrst, // asynchronous reset, active low
  input wire [4:0] addr, // register byte address
  input wire [7:0] wdata, // write data
  input wire wr, // write strobe
  input wire rd, // read strobe
  output reg [7:0] rdata_q, // read data, valid the cycle after rd
  input wire [7:0] port_direction_bits, // general purpose direction, 1 = output
  input wire [7:0] port_data, // general purpose output data
  input wire [7:0] pin_in, // timer pin levels, asynchronous
  output wire [7:0] pin_out, // timer pin drive level
  output wire [7:0] pin_oe_n, // pin output enable, low drives
  input wire accumulator_input, // accumulator pin level, asynchronous
  output wire [7:0] chan_irq, // channel interrupt requests
  output wire ovf_irq, // counter overflow request
  output wire pa_ovf_irq, // accumulator overflow request
  output wire pa_in_irq // accumulator input request
);

  reg rst_s1_q;
  reg rst_n;
  reg [7:0] ios_q;
  reg [7:0] sys_q;
  reg [7:0] act_hi_q;
  reg [7:0] act_lo_q;
  reg [7:0] edge_hi_q;
  reg [7:0] edge_lo_q;
  reg [7:0] cmask_q;
  reg [7:0] ovfctl_q;
  reg [7:0] cflag_q;
  reg tof_q;
  reg [15:0] cnt_q;
  reg [7:0] accumulator_control_q;
  reg pa_ovf_q;
  reg pa_in_q;
  reg [15:0] pacnt_q;
  reg [5:0] pre_q;
  reg pai_s1_q;
  reg pai_s2_q;
  reg pai_s3_q;
  reg [5:0] pmask;
  reg [5:0] pmask_q;
  reg cnt_src;
  reg [7:0] rdata_d;

  wire [127:0] val_all;
  wire [7:0] ev;
  wire [7:0] fast_clr;
  wire [7:0] drv;
  wire [7:0] oc_all;

  // reset released through two flops; assertion stays asynchronous
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  wire timer_on = sys_q[`TFPA_B_TIMER_ON];
  wire ffca = sys_q[`TFPA_B_FFCA];
  wire [15:0] act = {act_hi_q, act_lo_q};
  wire [15:0] edg = {edge_hi_q, edge_lo_q};
  wire compare7_counter_reset_enable = ovfctl_q[`TFPA_B_COMPARE7_COUNTER_RESET_ENABLE];
  wire [2:0] dsel = ovfctl_q[`TFPA_B_PRESCALE +: 3];
  wire accumulator_enable = accumulator_control_q[`TFPA_B_PA_EN];
  wire accumulator_mode_select = accumulator_control_q[`TFPA_B_PA_MODE];
  wire accumulator_polarity = accumulator_control_q[`TFPA_B_PA_POL];
  wire [1:0] clk_sel = accumulator_control_q[`TFPA_B_CLK_SEL +: 2];
  wire acc = rd | wr;
  wire ctl_wr = wr & ~addr[4];
  wire cnt_acc = acc & ((addr == `TFPA_OFS_CNT_H) | (addr == `TFPA_OFS_CNT_L));
  wire pacnt_acc = acc & ((addr == `TFPA_OFS_PACNT_H) | (addr == `TFPA_OFS_PACNT_L));

  // register writes; counter writes are always ignored, since the counter has no write path
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ios_q <= `TFPA_RST_BYTE;
      sys_q <= `TFPA_RST_BYTE;
      act_hi_q <= `TFPA_RST_BYTE;
      act_lo_q <= `TFPA_RST_BYTE;
      edge_hi_q <= `TFPA_RST_BYTE;
      edge_lo_q <= `TFPA_RST_BYTE;
      cmask_q <= `TFPA_RST_BYTE;
      ovfctl_q <= `TFPA_RST_BYTE;
      accumulator_control_q <= `TFPA_RST_BYTE;
    end else if (ctl_wr) begin
      case (addr)
        `TFPA_OFS_SELECT: ios_q <= wdata;
        `TFPA_OFS_SYSCTL: sys_q <= wdata;
        `TFPA_OFS_ACT_HI: act_hi_q <= wdata;
        `TFPA_OFS_ACT_LO: act_lo_q <= wdata;
        `TFPA_OFS_EDGE_HI: edge_hi_q <= wdata;
        `TFPA_OFS_EDGE_LO: edge_lo_q <= wdata;
        `TFPA_OFS_CMASK: cmask_q <= wdata;
        `TFPA_OFS_OVFCTL: ovfctl_q <= wdata;
        `TFPA_OFS_ACCUMULATOR_CONTROL: accumulator_control_q <= wdata;
        default: ;
      endcase
    end
  end

  // prescaler stages, held at zero while the timer is off
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_q <= 6'h00;
    end else if (!timer_on) begin
      pre_q <= 6'h00;
    end else begin
      pre_q <= pre_q + 6'h01;
    end
  end

  always @* begin
    case (dsel)
      3'h0: pmask = 6'h00;
      3'h1: pmask = 6'h01;
      3'h2: pmask = 6'h03;
      3'h3: pmask = 6'h07;
      3'h4: pmask = 6'h0F;
      default: pmask = 6'h1F;
    endcase
  end

  // a new divisor waits until the low five divider stages roll over to zero,
  // so a change mid-period never yields a stray short count
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pmask_q <= 6'h00;
    end else if (!timer_on) begin
      pmask_q <= pmask;
    end else if (pre_q[4:0] == 5'h1F) begin
      pmask_q <= pmask;
    end
  end

  wire pre_tick = timer_on & ((pre_q & pmask_q) == pmask_q);
  // no divide-by-64 tick while the timer is off
  wire div64_tick = timer_on & (pre_q == `TFPA_DIV64_LAST);

  // accumulator pin: two flops, then an edge history flop
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pai_s1_q <= 1'b0;
      pai_s2_q <= 1'b0;
      pai_s3_q <= 1'b0;
    end else begin
      pai_s1_q <= accumulator_input;
      pai_s2_q <= pai_s1_q;
      pai_s3_q <= pai_s2_q;
    end
  end

  wire pai_rise = pai_s2_q & ~pai_s3_q;
  wire pai_fall = ~pai_s2_q & pai_s3_q;
  // the counted edge and the gate's trailing edge coincide for each polarity
  wire pa_edge = accumulator_polarity ? pai_rise : pai_fall;
  wire gate_lvl = accumulator_polarity ? ~pai_s2_q : pai_s2_q;
  wire accumulator_clock = accumulator_enable & (accumulator_mode_select ? (gate_lvl & div64_tick) : pa_edge);
  wire pa_in_set = accumulator_enable & pa_edge;
  // a software write beats the increment, so that cycle shows no wrap
  wire pa_inc = accumulator_clock & ~(wr & pacnt_acc);
  wire pa_wrap = pa_inc & (pacnt_q == `TFPA_MAX_WORD);
  wire pa_lo_wrap = pa_inc & (pacnt_q[7:0] == 8'hFF);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pacnt_q <= `TFPA_RST_WORD;
    end else if (wr & (addr == `TFPA_OFS_PACNT_H)) begin
      pacnt_q[15:8] <= wdata;
    end else if (wr & (addr == `TFPA_OFS_PACNT_L)) begin
      pacnt_q[7:0] <= wdata;
    end else if (accumulator_clock) begin
      pacnt_q <= pacnt_q + 16'h0001;
    end
  end

  // counter clock source; selection is combinational so a change acts at once
  always @* begin
    case (clk_sel)
      2'h0: cnt_src = pre_tick;
      2'h1: cnt_src = accumulator_clock;
      2'h2: cnt_src = pa_lo_wrap;
      default: cnt_src = pa_wrap;
    endcase
  end

  wire cnt_tick = timer_on & (accumulator_enable ? cnt_src : pre_tick);
  wire c7_reset = compare7_counter_reset_enable & ios_q[7] & (cnt_q == val_all[127:112]);
  wire tof_set = cnt_tick & ~c7_reset & (cnt_q == `TFPA_MAX_WORD);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= `TFPA_RST_WORD;
    end else if (cnt_tick) begin
      cnt_q <= c7_reset ? `TFPA_RST_WORD : cnt_q + 16'h0001;
    end
  end

  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_ch
      localparam [2:0] CH = i;
      reg [15:0] val_q;
      reg oc_q;
      reg p1_q;
      reg p2_q;
      reg p3_q;
      wire [1:0] pair = act[2 * i +: 2];
      wire [1:0] esel = edg[2 * i +: 2];
      wire rise = p2_q & ~p3_q;
      wire fall = ~p2_q & p3_q;
      wire cap = ~ios_q[i] & ((esel[0] & rise) | (esel[1] & fall));
      wire cmp = ios_q[i] & cnt_tick & (cnt_q == val_q);
      wire vsel = addr[4] & (addr[3:1] == CH);
      wire wr_hi = wr & vsel & ~addr[0] & ios_q[i];
      wire wr_lo = wr & vsel & addr[0] & ios_q[i];

      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          p1_q <= 1'b0;
          p2_q <= 1'b0;
          p3_q <= 1'b0;
        end else begin
          p1_q <= pin_in[i];
          p2_q <= p1_q;
          p3_q <= p2_q;
        end
      end

      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          val_q <= `TFPA_RST_WORD;
        end else if (cap) begin
          val_q <= cnt_q;
        end else if (wr_hi) begin
          val_q[15:8] <= wdata;
        end else if (wr_lo) begin
          val_q[7:0] <= wdata;
        end
      end

      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          oc_q <= 1'b0;
        end else if (cmp) begin
          case (pair)
            2'h1: oc_q <= ~oc_q;
            2'h2: oc_q <= 1'b0;
            2'h3: oc_q <= 1'b1;
            default: oc_q <= oc_q;
          endcase
        end
      end

      assign val_all[16 * i +: 16] = val_q;
      assign ev[i] = cap | cmp;
      assign fast_clr[i] = ffca & vsel & (ios_q[i] ? wr : rd);
      assign drv[i] = ios_q[i] & (|pair);
      assign oc_all[i] = oc_q;
    end
  endgenerate

  assign pin_oe_n = ~(drv | port_direction_bits);
  assign pin_out = (drv & oc_all) | (~drv & port_data);

  // flags: a set in the same cycle as a clear wins
  wire [7:0] cflag_w1c = (wr & (addr == `TFPA_OFS_CFLAG)) ? wdata : 8'h00;
  wire tof_clr = (wr & (addr == `TFPA_OFS_OFLAG) & wdata[`TFPA_B_TOF])
    | (ffca & cnt_acc);
  wire paf_wr = wr & (addr == `TFPA_OFS_PAFLAG);
  wire pa_fast = ffca & pacnt_acc;
  wire pa_ovf_clr = (paf_wr & wdata[`TFPA_B_PA_OVF]) | pa_fast;
  wire pa_in_clr = (paf_wr & wdata[`TFPA_B_PA_IN]) | pa_fast;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cflag_q <= `TFPA_RST_BYTE;
      tof_q <= 1'b0;
      pa_ovf_q <= 1'b0;
      pa_in_q <= 1'b0;
    end else begin
      cflag_q <= (cflag_q & ~(cflag_w1c | fast_clr)) | ev;
      tof_q <= (tof_q & ~tof_clr) | tof_set;
      pa_ovf_q <= (pa_ovf_q & ~pa_ovf_clr) | pa_wrap;
      pa_in_q <= (pa_in_q & ~pa_in_clr) | pa_in_set;
    end
  end

  // one level per source; priority is left to the interrupt controller
  assign chan_irq = cflag_q & cmask_q;
  assign ovf_irq = tof_q & ovfctl_q[`TFPA_B_OVF_IE];
  assign pa_ovf_irq = pa_ovf_q & accumulator_control_q[`TFPA_B_PA_OVF_IE];
  assign pa_in_irq = pa_in_q & accumulator_control_q[`TFPA_B_PA_IN_IE];

  // read mux; unmapped addresses read zero
  wire [15:0] val_sel = val_all[{addr[3:1], 4'h0} +: 16];

  always @* begin
    rdata_d = 8'h00;
    if (addr[4]) begin
      rdata_d = addr[0] ? val_sel[7:0] : val_sel[15:8];
    end else begin
      case (addr)
        `TFPA_OFS_SELECT: rdata_d = ios_q;
        `TFPA_OFS_SYSCTL: rdata_d = sys_q;
        `TFPA_OFS_ACT_HI: rdata_d = act_hi_q;
        `TFPA_OFS_ACT_LO: rdata_d = act_lo_q;
        `TFPA_OFS_EDGE_HI: rdata_d = edge_hi_q;
        `TFPA_OFS_EDGE_LO: rdata_d = edge_lo_q;
        `TFPA_OFS_CMASK: rdata_d = cmask_q;
        `TFPA_OFS_OVFCTL: rdata_d = ovfctl_q;
        `TFPA_OFS_CFLAG: rdata_d = cflag_q;
        `TFPA_OFS_OFLAG: rdata_d = {tof_q, 7'h00};
        `TFPA_OFS_CNT_H: rdata_d = cnt_q[15:8];
        `TFPA_OFS_CNT_L: rdata_d = cnt_q[7:0];
        `TFPA_OFS_ACCUMULATOR_CONTROL: rdata_d = accumulator_control_q;
        `TFPA_OFS_PAFLAG: rdata_d = {6'h00, pa_ovf_q, pa_in_q};
        `TFPA_OFS_PACNT_H: rdata_d = pacnt_q[15:8];
        `TFPA_OFS_PACNT_L: rdata_d = pacnt_q[7:0];
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // data stands only in the cycle after the read strobe
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else if (rd) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= 8'h00;
    end
  end

endmodule
`default_nettype wire

/* tb/tfpa_pins.sv */
// tfpa_pins.sv: far-side pin model for the timer block
// assumes the bench sets levels and holds each one for more than two clocks
`timescale 1ns/1ps
`default_nettype none
module tfpa_pins (
  input wire [7:0] ext_lvl, // outside levels
  input wire pa_lvl, // outside accumulator level
  input wire [7:0] pin_out, // design drive
  input wire [7:0] pin_oe_n, // low drives
  output wire [7:0] pin_in, // resolved levels
  output wire accumulator_input // resolved accumulator pin
);
  // a driven pin reads back the design's level, not the outside one
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_lvl);
  assign accumulator_input = pa_lvl;
endmodule
`default_nettype wire

/* tb/tfpa_timer_checker.sv */
// tfpa_timer_checker.sv: port assertions for the timer block
// assumes it is bound to tfpa_timer and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module tfpa_timer_checker (
  input wire clk, // clock
  input wire nrst, // reset, low active
  input wire [4:0] addr, // address
  input wire [7:0] wdata, // write data
  input wire wr, // write strobe
  input wire rd, // read strobe
  input wire [7:0] rdata_q, // read data
  input wire [7:0] chan_irq, // channel requests
  input wire ovf_irq, // overflow request
  input wire pa_ovf_irq, // accumulator overflow request
  input wire pa_in_irq // accumulator input request
);
  logic ffca_q;
  logic [7:0] sel_q;
  wire [2:0] ch = addr[3:1];
  // shadows of the fast-clear bit and the select register the fast-clear checks need
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ffca_q <= 1'b0;
      sel_q <= 8'h00;
    end else begin
      if (wr && addr == 5'h01) ffca_q <= wdata[4];
      if (wr && addr == 5'h00) sel_q <= wdata;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  chk_read_idle_zero: assert property (!$past(rd) |-> rdata_q == 8'h00)
    else $error("read data not zero outside read slot");
  chk_mask_gates_chan: assert property (
    (wr && addr == 5'h06) |=> (chan_irq & ~$past(wdata)) == 8'h00)
    else $error("masked channel still requests");
  chk_ovf_masked: assert property ((wr && addr == 5'h07 && !wdata[7]) ##1 1'b1 |-> !ovf_irq)
    else $error("masked overflow still requests");
  chk_pa_ovf_masked: assert property ((wr && addr == 5'h0C && !wdata[1]) |=> !pa_ovf_irq)
    else $error("masked accumulator overflow still requests");
  chk_pa_in_masked: assert property ((wr && addr == 5'h0C && !wdata[0]) |=> !pa_in_irq)
    else $error("masked accumulator input still requests");
  chk_fast_chan_clear: assert property (
    (ffca_q && addr[4] && ((rd && !sel_q[ch]) || (wr && sel_q[ch]))) |=> !chan_irq[$past(ch)])
    else $error("fast clear left channel request");
  chk_fast_ovf_clear: assert property (
    (ffca_q && (rd || wr) && addr[4:1] == 4'h5) |=> !ovf_irq)
    else $error("fast clear left overflow request");
  chk_fast_pa_clear: assert property (
    (ffca_q && (rd || wr) && addr[4:1] == 4'h7) |=> !pa_ovf_irq && !pa_in_irq)
    else $error("fast clear left accumulator request");
  chk_zero_write_keeps: assert property (
    (!ffca_q && wr && addr == 5'h08 && wdata == 8'h00) |=> ($past(chan_irq) & ~chan_irq) == 8'h00)
    else $error("writing zero cleared a flag");
endmodule
bind tfpa_timer tfpa_timer_checker chk_u (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata_q(rdata_q), .chan_irq(chan_irq), .ovf_irq(ovf_irq),
  .pa_ovf_irq(pa_ovf_irq), .pa_in_irq(pa_in_irq));
`default_nettype wire

/* tb/tb_top.sv */
// tb_top.sv: scenario bench for the timer block and its pin model
// assumes design, checker and pin model compile first
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [4:0] addr = 5'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] ext = 8'h00;
  logic pa = 1'b0;
  logic [7:0] got;
  logic [7:0] dlt;
  logic [7:0] ddr = 8'h00;
  logic [7:0] pdat = 8'h00;
  logic [15:0] cv;
  logic pv;
  int errors = 0;
  int samples_checked = 0;
  wire [7:0] rdata_q, pin_in, pin_out, pin_oe_n, chan_irq;
  wire acc_in, ovf_irq, pa_ovf_irq, pa_in_irq;
  wire [10:0] irq = {chan_irq, ovf_irq, pa_ovf_irq, pa_in_irq};
  always #5 clk = ~clk;
  tfpa_timer dut_u (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata_q(rdata_q), .port_direction_bits(ddr), .port_data(pdat), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .accumulator_input(acc_in), .chan_irq(chan_irq),
    .ovf_irq(ovf_irq), .pa_ovf_irq(pa_ovf_irq), .pa_in_irq(pa_in_irq));
  tfpa_pins pins_u (.ext_lvl(ext), .pa_lvl(pa), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pin_in(pin_in), .accumulator_input(acc_in));
  task automatic conclude;
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // a spare cycle after each strobe keeps every signal at one change per edge
  task automatic wreg(input logic [4:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rreg(input logic [4:0] a);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    got = rdata_q;
  endtask
  task automatic waiti(input int b, input int lim);
    int n;
    n = 0;
    while (irq[b] !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
    check({15'h0, irq[b]}, 16'h0001);
    if (irq[b] !== 1'b1) conclude();
  endtask
  task automatic pulse;
    pa <= 1'b1;
    repeat (4) @(posedge clk);
    pa <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic t_capture;
    wreg(5'h01, 8'h80);
    for (int c = 0; c < 4; c++) begin
      wreg(5'h08, 8'h01);
      wreg(5'h05, c[7:0]);
      ext <= 8'h01;
      repeat (8) @(posedge clk);
      rreg(5'h08);
      check(got[0], c[0]);
      wreg(5'h08, 8'h01);
      ext <= 8'h00;
      repeat (8) @(posedge clk);
      rreg(5'h08);
      check(got[0], c[1]);
    end
    wreg(5'h06, 8'h01);
    check(irq[3], 1'b1);
    wreg(5'h08, 8'h00);
    check(irq[3], 1'b1);
    wreg(5'h06, 8'h00);
    check(irq[3], 1'b0);
    rreg(5'h11);
    cv[7:0] = got;
    wreg(5'h11, ~got);
    rreg(5'h11);
    check(got, cv[7:0]);
    wreg(5'h01, 8'h90);
    rreg(5'h10);
    rreg(5'h08);
    check(got[0], 1'b0);
  endtask
  task automatic t_compare;
    logic [7:0] seq [3] = '{8'h08, 8'h0C, 8'h04};
    pv = 1'b0;
    wreg(5'h01, 8'h80);
    wreg(5'h00, 8'h02);
    wreg(5'h06, 8'h02);
    foreach (seq[i]) begin
      wreg(5'h03, seq[i]);
      wreg(5'h08, 8'h02);
      rreg(5'h0B);
      cv[7:0] = got;
      rreg(5'h0A);
      cv = {got, cv[7:0]} + 16'h0040;
      wreg(5'h12, cv[15:8]);
      wreg(5'h13, cv[7:0]);
      waiti(4, 600);
      repeat (2) @(posedge clk);
      pv = (seq[i] == 8'h04) ? ~pv : seq[i][2];
      check(pin_out[1], pv);
      check(pin_oe_n[1], 1'b0);
    end
    wreg(5'h01, 8'h90);
    wreg(5'h13, cv[7:0]);
    check(irq[4], 1'b0);
    wreg(5'h03, 8'h00);
    check(pin_oe_n[1], 1'b1);
    ddr <= 8'h02;
    pdat <= 8'h02;
    @(posedge clk);
    check(pin_oe_n[1], 1'b0);
    check(pin_out[1], 1'b1);
    ddr <= 8'h00;
    pdat <= 8'h00;
    @(posedge clk);
  endtask
  task automatic t_counter;
    wreg(5'h01, 8'h80);
    wreg(5'h07, 8'h80);
    waiti(2, 70000);
    rreg(5'h09);
    check(got, 8'h80);
    wreg(5'h01, 8'h90);
    rreg(5'h0B);
    check(irq[2], 1'b0);
    wreg(5'h07, 8'h08);
    wreg(5'h00, 8'h80);
    wreg(5'h1E, 8'h04);
    wreg(5'h1F, 8'h00);
    wreg(5'h06, 8'h80);
    waiti(10, 1200);
    rreg(5'h0A);
    check(got, 8'h00);
  endtask
  task automatic t_acc;
    wreg(5'h01, 8'h00);
    wreg(5'h0C, 8'h51);
    repeat (3) pulse();
    rreg(5'h0F);
    check(got, 8'h03);
    check(irq[0], 1'b1);
    wreg(5'h0D, 8'h01);
    check(irq[0], 1'b0);
    wreg(5'h0C, 8'h41);
    pa <= 1'b1;
    repeat (8) @(posedge clk);
    rreg(5'h0F);
    check(got, 8'h03);
    pa <= 1'b0;
    repeat (8) @(posedge clk);
    rreg(5'h0F);
    check(got, 8'h04);
    wreg(5'h0E, 8'hFF);
    wreg(5'h0F, 8'hFF);
    wreg(5'h0C, 8'h53);
    pulse();
    check(irq[1], 1'b1);
    wreg(5'h01, 8'h10);
    rreg(5'h0E);
    check(irq[1:0], 2'b00);
    wreg(5'h01, 8'h80);
    wreg(5'h0C, 8'h61);
    pa <= 1'b1;
    repeat (200) @(posedge clk);
    pa <= 1'b0;
    repeat (8) @(posedge clk);
    check(irq[0], 1'b1);
    rreg(5'h0F);
    check(got > 8'h01 && got < 8'h05, 1'b1);
    wreg(5'h0C, 8'h00);
    check(irq[0], 1'b0);
  endtask
  // 64-edge windows hold an exact number of prescaler ticks at any phase
  task automatic t_clock;
    logic [7:0] dv [4] = '{8'h00, 8'h03, 8'h04, 8'h06};
    logic [7:0] ex [4] = '{8'h40, 8'h08, 8'h04, 8'h02};
    wreg(5'h0C, 8'h14);
    foreach (dv[i]) begin
      wreg(5'h07, dv[i]);
      repeat (40) @(posedge clk);
      rreg(5'h0B);
      cv[7:0] = got;
      repeat (62) @(posedge clk);
      rreg(5'h0B);
      dlt = got - cv[7:0];
      check(dlt, ex[i]);
    end
    wreg(5'h0C, 8'h54);
    rreg(5'h0B);
    cv[7:0] = got;
    repeat (2) pulse();
    rreg(5'h0B);
    dlt = got - cv[7:0];
    check(dlt, 8'h02);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    rreg(5'h08);
    check(got, 8'h00);
    check(irq, 11'h000);
    t_capture();
    t_compare();
    t_counter();
    t_acc();
    t_clock();
    conclude();
  end
endmodule
`default_nettype wire
